// ---- src/pic_top.sv ----
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pic_top
   import pic_pkg::*;
#(
   parameter int NUM_LED = 2,
   parameter int MS_CYCLES = MS_CYC,
   parameter int PWM_CYCLES = PWM_CYC,
   parameter int MAX_FRAMES = GEN_MAX_FRAMES
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [5:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_standby_hold_pin,
   input wire logic i_link_up,
   input wire logic i_speed100,
   input wire logic i_integrity_fail,
   input wire logic i_early_fail,
   input wire logic i_magic_det,
   input wire logic i_collision,
   input wire logic i_activity,
   input wire pic_byte_t i_mac_tx,
   input wire pic_byte_t i_med_rx,
   output pic_byte_t o_med_tx,
   output pic_byte_t o_mac_rx,
   output logic [3:0] o_rxd_hi,
   output logic o_rxd_hi_sel,
   output logic [NUM_LED-1:0] o_led_n,
   output logic o_link_loss_alert_pin,
   output logic o_mgmt_interrupt_n
);
   localparam int MSW = $clog2(MS_CYCLES);
   localparam int PWW = $clog2(PWM_CYCLES);

   logic [15:0] ctrl_ff, maccfg_ff, imask_ff, istat_ff, ledmode_ff, ledbeh_ff;
   logic [15:0] ledext_ff, ext2_ff, gp25_ff, genctl_ff, gencfg_ff;
   logic [4:0] srst_cnt_ff;
   logic srst_done;
   logic [2:0] hold_sync_ff;
   logic [MSW-1:0] ms_cnt_ff;
   logic ms_tick;
   logic [PWW-1:0] pwm_cnt_ff;
   logic [31:0] pwm_thr;
   logic [8:0] blink_cnt_ff;
   logic blink_ph_ff;
   logic [9:0] boot_cnt_ff;
   logic flf_raw, flf_prev_ff;
   logic wr_istat_rd;
   pic_gen_st_t gen_st_ff;
   logic [11:0] idx_ff;
   logic [11:0] frame_len;
   logic [24:0] frames_ff;
   logic [31:0] crc_ff;
   pic_byte_t gen_byte;
   pic_byte_t nxt_med_tx, nxt_mac_rx;
   logic [7:0] prev_tx_ff, prev_rx_ff;
   logic pcs_clk_ff;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      return r;
   endfunction

   function automatic logic is_wr(input logic [5:0] a);
      return i_wr && i_addr == a;
   endfunction

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         maccfg_ff <= RST_VAL;
         imask_ff <= RST_VAL;
         ledmode_ff <= RST_LEDMODE;
         ledbeh_ff <= RST_VAL;
         ledext_ff <= RST_VAL;
         ext2_ff <= RST_VAL;
         gp25_ff <= RST_VAL;
         gencfg_ff <= RST_VAL;
      end
      else
      begin
         if (is_wr(A_MACCFG))
            maccfg_ff <= i_wdata;
         if (is_wr(A_IMASK))
            imask_ff <= i_wdata;
         if (is_wr(A_LEDMODE))
            ledmode_ff <= i_wdata;
         if (is_wr(A_LEDBEH))
            ledbeh_ff <= i_wdata;
         if (is_wr(A_LEDEXT))
            ledext_ff <= i_wdata;
         if (is_wr(A_EXT2))
            ext2_ff <= i_wdata;
         if (is_wr(A_GP25))
            gp25_ff <= i_wdata;
         if (is_wr(A_GENCFG))
            gencfg_ff <= i_wdata;
      end
   end

   // ----------------------------------------
   // control with self-clearing soft reset
   // ----------------------------------------
   assign srst_done = ctrl_ff[B_SRST] && srst_cnt_ff == 5'(SRST_CYC - 1);

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl_ff <= RST_VAL;
         srst_cnt_ff <= 5'h00;
      end
      else
      begin
         if (is_wr(A_CTRL))
            ctrl_ff <= i_wdata;
         else if (srst_done)
            ctrl_ff[B_SRST] <= 1'b0;
         srst_cnt_ff <= ctrl_ff[B_SRST] ? srst_cnt_ff + 5'h01 : 5'h00;
      end
   end

   // ----------------------------------------
   // read port, one cycle latency
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_rdata <= 16'h0000;
      else if (i_rd)
      begin
         unique case (i_addr)
            A_CTRL: o_rdata <= ctrl_ff;
            A_STAT: o_rdata <= 16'(i_link_up) << B_LINK;
            A_MACCFG: o_rdata <= maccfg_ff;
            A_IMASK: o_rdata <= imask_ff;
            A_ISTAT: o_rdata <= istat_ff;
            A_LEDMODE: o_rdata <= ledmode_ff;
            A_LEDBEH: o_rdata <= ledbeh_ff;
            A_LEDEXT: o_rdata <= ledext_ff;
            A_EXT2: o_rdata <= ext2_ff;
            A_GP25: o_rdata <= gp25_ff;
            A_GENCTL: o_rdata <= genctl_ff;
            A_GENCFG: o_rdata <= gencfg_ff;
            default: o_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------
   // interrupts and link loss
   // ----------------------------------------
   assign flf_raw = i_speed100 ? i_integrity_fail : ~i_link_up;
   assign wr_istat_rd = i_rd && i_addr == A_ISTAT;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         istat_ff <= 16'h0000;
         flf_prev_ff <= 1'b0;
         o_link_loss_alert_pin <= 1'b0;
         o_mgmt_interrupt_n <= 1'b1;
      end
      else
      begin
         flf_prev_ff <= flf_raw;
         // clear on read, a new event in the same cycle survives
         if (wr_istat_rd)
            istat_ff <= 16'h0000;
         if (i_magic_det && imask_ff[B_WOL])
            istat_ff[B_WOL] <= 1'b1;
         if (ext2_ff[B_FLF_EN] && i_speed100 && flf_raw && !flf_prev_ff)
            istat_ff[B_FLF] <= 1'b1;
         o_link_loss_alert_pin <= ext2_ff[B_FLF_EN] & (flf_raw
            | (ext2_ff[B_EARLY_EN] & i_speed100 & i_early_fail));
         o_mgmt_interrupt_n <= ~((istat_ff[B_WOL] & imask_ff[B_WOL])
            | (istat_ff[B_FLF] & imask_ff[B_FLF]));
      end
   end

   // ----------------------------------------
   // prescalers and LED timing
   // ----------------------------------------
   assign ms_tick = ms_cnt_ff == MSW'(MS_CYCLES - 1);
   assign pwm_thr = (32'(gp25_ff[15:8]) * 32'(PWM_CYCLES)) >> 8;

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ms_cnt_ff <= '0;
         pwm_cnt_ff <= '0;
         blink_cnt_ff <= 9'h000;
         blink_ph_ff <= 1'b0;
      end
      else
      begin
         ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 1'b1;
         pwm_cnt_ff <= (pwm_cnt_ff == PWW'(PWM_CYCLES - 1)) ? '0 : pwm_cnt_ff + 1'b1;
         if (ms_tick)
         begin
            if (blink_cnt_ff + 9'h001 >= pic_blink_half_ms(ledbeh_ff[B_BLINK_RATE +: 2]))
            begin
               blink_cnt_ff <= 9'h000;
               blink_ph_ff <= ~blink_ph_ff;
            end
            else
               blink_cnt_ff <= blink_cnt_ff + 9'h001;
         end
      end
   end

   // standby pin is asynchronous: two flops, then edge on the third
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         hold_sync_ff <= 3'h0;
         boot_cnt_ff <= 10'h000;
      end
      else
      begin
         hold_sync_ff <= {hold_sync_ff[1:0], i_standby_hold_pin};
         if (ledext_ff[B_BOOT_BLINK] && (srst_done || (hold_sync_ff[2] && !hold_sync_ff[1])))
            boot_cnt_ff <= 10'(T_BOOT_BLINK_MS);
         else if (ms_tick && boot_cnt_ff != 10'h000)
            boot_cnt_ff <= boot_cnt_ff - 10'h001;
      end
   end

   for (genvar g = 0; g < NUM_LED; g++)
   begin : g_led
      pic_led_chan u_led (
         .i_clk(i_clk),
         .i_rst_b(i_rst_b),
         .i_mode(ledmode_ff[4*g +: 4]),
         .i_stretch(ledbeh_ff[g]),
         .i_stretch_ms(pic_stretch_ms(ledbeh_ff[B_STRETCH_RATE +: 2])),
         .i_ms_tick(ms_tick),
         .i_blink_ph(blink_ph_ff),
         .i_boot_blink(boot_cnt_ff != 10'h000),
         .i_pulse_en(ledbeh_ff[B_PULSE_EN]),
         .i_pwm_on(32'(pwm_cnt_ff) < pwm_thr),
         .i_link(i_link_up),
         .i_col(i_collision),
         .i_act(i_activity),
         .o_led_n(o_led_n[g])
      );
   end

   // ----------------------------------------
   // test frame generator
   // ----------------------------------------
   // header 8 + addresses 12 + payload + fcs 4
   assign frame_len = 12'd24 + {3'h0, gencfg_ff[14:12], 6'h00} + 12'd46;

   always_comb
   begin
      gen_byte = '{vld: gen_st_ff == GEN_BODY, dat: 8'h00};
      if (idx_ff < 12'd7)
         gen_byte.dat = PREAMBLE;
      else if (idx_ff == 12'd7)
         gen_byte.dat = SFD;
      else if (idx_ff < 12'd14)
         gen_byte.dat = genctl_ff[7:0];
      else if (idx_ff < 12'd20)
         gen_byte.dat = {2{genctl_ff[11:8]}};
      else if (idx_ff < frame_len - 12'd4)
         gen_byte.dat = gencfg_ff[7:0];
      else
      begin
         gen_byte.dat = crc_ff[8*(idx_ff - (frame_len - 12'd4)) +: 8];
         if (!gencfg_ff[B_BAD_FCS])
            gen_byte.dat = ~gen_byte.dat;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         genctl_ff <= RST_VAL;
         gen_st_ff <= GEN_IDLE;
         idx_ff <= 12'h000;
         frames_ff <= 25'h0000000;
         crc_ff <= 32'hffffffff;
      end
      else
      begin
         if (is_wr(A_GENCTL))
         begin
            genctl_ff <= i_wdata;
            frames_ff <= 25'h0000000;
         end
         unique case (gen_st_ff)
            GEN_IDLE:
               if (genctl_ff[B_GEN_EN] && genctl_ff[B_GEN_GO])
               begin
                  gen_st_ff <= GEN_BODY;
                  idx_ff <= 12'h000;
               end
            GEN_BODY:
            begin
               // freeze the sum while its own bytes go out
               if (idx_ff <= 12'd7)
                  crc_ff <= 32'hffffffff;
               else if (idx_ff < frame_len - 12'd4)
                  crc_ff <= crc_byte(crc_ff, gen_byte.dat);
               idx_ff <= idx_ff + 12'h001;
               if (idx_ff == frame_len - 12'h001)
               begin
                  gen_st_ff <= GEN_GAP;
                  idx_ff <= 12'h000;
                  frames_ff <= is_wr(A_GENCTL) ? 25'h0000000 : frames_ff + 25'h0000001;
                  if (!genctl_ff[B_GEN_CONT] && frames_ff == 25'(MAX_FRAMES - 1)
                      && !is_wr(A_GENCTL))
                     genctl_ff[B_GEN_GO] <= 1'b0;
               end
            end
            GEN_GAP:
            begin
               idx_ff <= idx_ff + 12'h001;
               if (idx_ff >= {8'h00, gencfg_ff[11:8]} + 12'd11)
                  gen_st_ff <= GEN_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // data path, loopbacks and frame-start pins
   // ----------------------------------------
   always_comb
   begin
      nxt_med_tx = i_mac_tx;
      if (ctrl_ff[B_NEAR_LB])
         nxt_med_tx = '0;
      else if (genctl_ff[B_GEN_EN])
         nxt_med_tx = gen_byte;
      else if (maccfg_ff[B_FAR_LB])
         nxt_med_tx = i_med_rx;
      nxt_mac_rx = i_med_rx;
      if (ctrl_ff[B_ISOLATE])
         nxt_mac_rx = '0;
      else if (ctrl_ff[B_NEAR_LB])
         nxt_mac_rx = i_mac_tx;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_med_tx <= '0;
         o_mac_rx <= '0;
         prev_tx_ff <= 8'h00;
         prev_rx_ff <= 8'h00;
         pcs_clk_ff <= 1'b0;
         o_rxd_hi <= 4'h0;
         o_rxd_hi_sel <= 1'b0;
      end
      else
      begin
         o_med_tx <= nxt_med_tx;
         o_mac_rx <= nxt_mac_rx;
         if (nxt_med_tx.vld)
            prev_tx_ff <= nxt_med_tx.dat;
         if (i_med_rx.vld)
            prev_rx_ff <= i_med_rx.dat;
         pcs_clk_ff <= ~pcs_clk_ff;
         o_rxd_hi_sel <= ext2_ff[B_SOF_EN] && maccfg_ff[B_MAC_LO +: 2] != MAC_MII;
         o_rxd_hi <= {i_med_rx.vld && i_med_rx.dat == SFD && prev_rx_ff == PREAMBLE,
            ~pcs_clk_ff,
            nxt_med_tx.vld && nxt_med_tx.dat == SFD && prev_tx_ff == PREAMBLE,
            ~pcs_clk_ff};
      end
   end
endmodule
`default_nettype wire

// ---- src/pic_pkg.sv ----
package pic_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_NS = 10;
   localparam int T_MS_NS = 1_000_000;
   localparam int MS_CYC = T_MS_NS / CLK_NS;
   localparam int T_PWM_HZ = 5000;
   localparam int PWM_CYC = 1_000_000_000 / (T_PWM_HZ * CLK_NS);
   localparam int T_BOOT_BLINK_MS = 1000;
   localparam int SRST_CYC = 16;
   localparam int GEN_MAX_FRAMES = 30_000_000;
   // link-loss answers in one clock cycle, well inside both bounds
   localparam int T_FLF_MAX_US = 3000;
   localparam int T_EARLY_MAX_US = 150;

   // ----------------------------------------
   // register map (6-bit word address)
   // ----------------------------------------
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_STAT = 6'h01;
   localparam logic [5:0] A_MACCFG = 6'h17;
   localparam logic [5:0] A_IMASK = 6'h19;
   localparam logic [5:0] A_ISTAT = 6'h1a;
   localparam logic [5:0] A_LEDMODE = 6'h1d;
   localparam logic [5:0] A_LEDBEH = 6'h1e;
   localparam logic [5:0] A_LEDEXT = 6'h33;
   localparam logic [5:0] A_EXT2 = 6'h34;
   localparam logic [5:0] A_GP25 = 6'h39;
   localparam logic [5:0] A_GENCTL = 6'h3d;
   localparam logic [5:0] A_GENCFG = 6'h3e;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_SRST = 15;
   localparam int B_NEAR_LB = 14;
   localparam int B_ISOLATE = 10;
   localparam int B_LINK = 2;
   localparam int B_FAR_LB = 3;
   localparam int B_MAC_LO = 11;
   localparam int B_WOL = 6;
   localparam int B_FLF = 7;
   localparam int B_PULSE_EN = 12;
   localparam int B_BLINK_RATE = 2;
   localparam int B_STRETCH_RATE = 4;
   localparam int B_BOOT_BLINK = 11;
   localparam int B_EARLY_EN = 15;
   localparam int B_FLF_EN = 14;
   localparam int B_SOF_EN = 12;
   localparam int B_GEN_EN = 15;
   localparam int B_GEN_GO = 14;
   localparam int B_GEN_CONT = 13;
   localparam int B_BAD_FCS = 15;

   localparam logic [15:0] RST_VAL = 16'h0000;
   localparam logic [15:0] RST_LEDMODE = 16'h00a9;
   localparam logic [3:0] M_LINK = 4'h6;
   localparam logic [3:0] M_COL = 4'h9;
   localparam logic [3:0] M_ACT = 4'ha;
   localparam logic [3:0] M_OFF = 4'he;
   localparam logic [3:0] M_ON = 4'hf;
   localparam logic [1:0] MAC_MII = 2'h0;
   localparam logic [7:0] PREAMBLE = 8'h55;
   localparam logic [7:0] SFD = 8'hd5;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;

   typedef struct packed {
      logic vld;
      logic [7:0] dat;
   } pic_byte_t;

   typedef enum logic [1:0] {GEN_IDLE, GEN_BODY, GEN_GAP} pic_gen_st_t;

   // blink half periods 200/100/50/25 ms, stretch 50/100/200/400 ms
   function automatic logic [8:0] pic_blink_half_ms(input logic [1:0] r);
      return 9'(200 >> r);
   endfunction

   function automatic logic [8:0] pic_stretch_ms(input logic [1:0] r);
      return 9'(50 << r);
   endfunction
endpackage

// ---- src/pic_led_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module pic_led_chan
   import pic_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [3:0] i_mode,
   input wire logic i_stretch,
   input wire logic [8:0] i_stretch_ms,
   input wire logic i_ms_tick,
   input wire logic i_blink_ph,
   input wire logic i_boot_blink,
   input wire logic i_pulse_en,
   input wire logic i_pwm_on,
   input wire logic i_link,
   input wire logic i_col,
   input wire logic i_act,
   output logic o_led_n
);
   logic event_now;
   logic str_on_ff;
   logic seen_ff;
   logic [8:0] hold_ff;
   logic on_now;

   // ----------------------------------------
   // event select
   // ----------------------------------------
   always_comb
   begin
      event_now = 1'b0;
      if (i_mode == M_COL)
         event_now = i_col;
      else if (i_mode == M_ACT)
         event_now = i_act;
   end

   // ----------------------------------------
   // pulse stretch: each state held for the minimum time
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         str_on_ff <= 1'b0;
         seen_ff <= 1'b0;
         hold_ff <= 9'h000;
      end
      else if (hold_ff != 9'h000)
      begin
         seen_ff <= seen_ff | event_now;
         if (i_ms_tick)
            hold_ff <= hold_ff - 9'h001;
      end
      else if ((seen_ff | event_now) != str_on_ff)
      begin
         str_on_ff <= seen_ff | event_now;
         seen_ff <= 1'b0;
         // one extra tick, since the first may come right away
         hold_ff <= i_stretch_ms + 9'h001;
      end
      else
         seen_ff <= 1'b0;
   end

   always_comb
   begin
      unique case (i_mode)
         M_ON: on_now = 1'b1;
         M_OFF: on_now = 1'b0;
         M_LINK: on_now = i_link;
         M_COL, M_ACT: on_now = i_stretch ? str_on_ff : (event_now & i_blink_ph);
         default: on_now = 1'b0;
      endcase
      // forced-on suppresses the after-reset blink
      if (i_boot_blink && i_mode != M_ON)
         on_now = i_blink_ph;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_led_n <= 1'b1;
      else
         o_led_n <= ~(on_now & (~i_pulse_en | i_pwm_on));
   end
endmodule
`default_nettype wire

// ---- tb/pic_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------
// port checks
// ------
module pic_sva
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [5:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic i_link_up,
   input wire logic i_integrity_fail,
   input wire logic i_early_fail,
   input wire logic [3:0] o_rxd_hi,
   input wire logic o_link_loss_alert_pin,
   input wire logic o_mgmt_interrupt_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire logic cause = !i_link_up || i_integrity_fail || i_early_fail;
   wire logic acc = i_rd || i_wr;
   property p_unmap;
      i_rd && i_addr == 6'h02 |=> o_rdata == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_hold;
      !$past(i_rd) |-> $stable(o_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
   // alert needs a live cause no more than two cycles back
   property p_alert;
      $rose(o_link_loss_alert_pin) |-> $past(cause) || $past(cause, 2);
   endproperty
   a_alert: assert property (p_alert) else $error("alert without cause");
   // interrupt only drops back within three cycles of a register read or write
   property p_int_clr;
      $rose(o_mgmt_interrupt_n) |-> $past(acc) || $past(acc, 2) || $past(acc, 3);
   endproperty
   a_int_clr: assert property (p_int_clr) else $error("interrupt cleared alone");
   property p_clk_pair;
      o_rxd_hi[2] == o_rxd_hi[0];
   endproperty
   a_clk_pair: assert property (p_clk_pair) else $error("timing clocks differ");
   property p_clk_run;
      $past(i_rst_b, 2) |-> o_rxd_hi[0] != $past(o_rxd_hi[0]);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("timing clock stalled");
   property p_rx_sof;
      o_rxd_hi[3] |=> !o_rxd_hi[3];
   endproperty
   a_rx_sof: assert property (p_rx_sof) else $error("rx frame pulse too long");
   property p_tx_sof;
      o_rxd_hi[1] |=> !o_rxd_hi[1];
   endproperty
   a_tx_sof: assert property (p_tx_sof) else $error("tx frame pulse too long");
   c_alert: cover property ($rose(o_link_loss_alert_pin));
   c_int: cover property ($fell(o_mgmt_interrupt_n));
   wire logic o_rxd_hi_q = o_rxd_hi[1];
   c_sof: cover property (o_rxd_hi[3] && o_rxd_hi_q);
endmodule
bind pic_top pic_sva u_sva (.i_clk, .i_rst_b, .i_addr, .i_wr, .i_rd, .o_rdata, .i_link_up,
   .i_integrity_fail, .i_early_fail, .o_rxd_hi, .o_link_loss_alert_pin, .o_mgmt_interrupt_n);
`default_nettype wire

// ---- tb/pic_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------
// frame source and byte sink on one side of a stream
// ------
module pic_mac_model
   import pic_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_send,
   input wire pic_byte_t i_rx,
   output pic_byte_t o_tx,
   output logic [7:0] o_rx_cnt
);
   logic [4:0] pos_ff;
   logic [7:0] idle_ff;
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         pos_ff <= 5'h00;
      else if (pos_ff == 5'h10)
         pos_ff <= 5'h00;
      else if (pos_ff != 5'h00 || i_send)
         pos_ff <= pos_ff + 5'h01;
   end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         idle_ff <= 8'h00;
      else
         idle_ff <= idle_ff + 8'h01;
   end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_rx_cnt <= 8'h00;
      else
         o_rx_cnt <= o_rx_cnt + 8'(i_rx.vld);
   end
   // idle data walks every cycle so a stale byte never looks valid
   assign o_tx = {pos_ff != 5'h00, (pos_ff == 5'h00) ? idle_ff : (pos_ff < 5'h08) ? PREAMBLE :
      (pos_ff == 5'h08) ? SFD : 8'(pos_ff)};
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pic_pkg::*;
;
   localparam int MSC = 20;
   logic i_clk = 1'b0;
   logic i_rst_b, i_wr, i_rd, i_link_up, i_speed100, i_integrity_fail, i_early_fail;
   logic i_magic_det, i_collision, i_activity, snd_mac, snd_med, o_rxd_hi_sel, hold_pin;
   logic o_link_loss_alert_pin, o_mgmt_interrupt_n;
   logic [5:0] i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [3:0] o_rxd_hi;
   logic [1:0] o_led_n;
   logic [7:0] mac_cnt, med_cnt, mac_base, med_base;
   pic_byte_t i_mac_tx, i_med_rx, o_med_tx, o_mac_rx;
   int bad_count, n_compared, cyc_cnt, k;
   pic_top #(.MS_CYCLES(MSC), .PWM_CYCLES(256), .MAX_FRAMES(2)) dut (.i_clk, .i_rst_b, .i_addr,
      .i_wdata, .i_wr, .i_rd, .o_rdata, .i_standby_hold_pin(hold_pin), .i_link_up, .i_speed100,
      .i_integrity_fail, .i_early_fail, .i_magic_det, .i_collision, .i_activity, .i_mac_tx,
      .i_med_rx, .o_med_tx, .o_mac_rx, .o_rxd_hi, .o_rxd_hi_sel, .o_led_n,
      .o_link_loss_alert_pin, .o_mgmt_interrupt_n);
   pic_mac_model u_mac (.i_clk, .i_rst_b, .i_send(snd_mac), .i_rx(o_mac_rx), .o_tx(i_mac_tx),
      .o_rx_cnt(mac_cnt));
   pic_mac_model u_med (.i_clk, .i_rst_b, .i_send(snd_med), .i_rx(o_med_tx), .o_tx(i_med_rx),
      .o_rx_cnt(med_cnt));
   initial forever #5 i_clk = ~i_clk;
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rc(input logic [5:0] a, input logic [15:0] e, input string nm);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(nm, o_rdata, e);
   endtask
   task automatic send(input logic m, input logic d);
      @(posedge i_clk);
      snd_mac <= m;
      snd_med <= d;
      @(posedge i_clk);
      snd_mac <= 1'b0;
      snd_med <= 1'b0;
      w(40);
   endtask
   // byte counts are taken as deltas since the previous check
   task automatic cnt(input logic [7:0] em, input logic [7:0] ed);
      chk("mac_rx", {8'h00, 8'(mac_cnt - mac_base)}, {8'h00, em});
      chk("med_tx", {8'h00, 8'(med_cnt - med_base)}, {8'h00, ed});
      mac_base = mac_cnt;
      med_base = med_cnt;
   endtask
   task automatic led_edge(input int i, output int n);
      logic v;
      v = o_led_n[i];
      n = 0;
      while (o_led_n[i] === v && n < 2000)
      begin
         w(1);
         n++;
      end
   endtask
   always @(posedge i_clk)
   begin
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // ------
   // main sequence
   // ------
   initial
   begin
      {i_rst_b, i_wr, i_rd, i_speed100, i_integrity_fail, i_early_fail, i_magic_det} = '0;
      {i_collision, i_activity, snd_mac, snd_med, i_addr, i_wdata, hold_pin} = '0;
      i_link_up = 1'b1;
      mac_base = 8'h00;
      med_base = 8'h00;
      repeat (20) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rc(A_LEDMODE, RST_LEDMODE, "ledmode");
      rc(A_CTRL, RST_VAL, "ctrl");
      rc(6'h02, 16'h0000, "unmapped");
      wr(A_CTRL, 16'h4000);
      send(1'b1, 1'b1);
      cnt(8'h10, 8'h00);
      wr(A_EXT2, 16'h1000);
      wr(A_MACCFG, 16'h0808);
      wr(A_CTRL, RST_VAL);
      send(1'b1, 1'b1);
      chk("sof_sel", 16'(o_rxd_hi_sel), 16'h0001);
      cnt(8'h10, 8'h10);
      wr(A_MACCFG, RST_VAL);
      wr(A_GENCTL, 16'hc000);
      send(1'b1, 1'b1);
      w(210);
      cnt(8'h10, 8'h8c);
      rc(A_GENCTL, 16'h8000, "genctl");
      wr(A_CTRL, 16'h0400);
      send(1'b0, 1'b1);
      cnt(8'h00, 8'h00);
      wr(A_CTRL, RST_VAL);
      wr(A_GENCTL, RST_VAL);
      wr(A_EXT2, 16'h4000);
      wr(A_IMASK, 16'h0080);
      @(posedge i_clk) i_link_up <= 1'b0;
      w(4);
      chk("alert10", 16'(o_link_loss_alert_pin), 16'h0001);
      chk("int10", 16'(o_mgmt_interrupt_n), 16'h0001);
      rc(A_ISTAT, 16'h0000, "istat10");
      @(posedge i_clk) i_link_up <= 1'b1;
      w(4);
      chk("alert10", 16'(o_link_loss_alert_pin), 16'h0000);
      @(posedge i_clk) i_speed100 <= 1'b1;
      @(posedge i_clk) i_integrity_fail <= 1'b1;
      w(4);
      chk("alert100", 16'(o_link_loss_alert_pin), 16'h0001);
      chk("int100", 16'(o_mgmt_interrupt_n), 16'h0000);
      @(posedge i_clk) i_integrity_fail <= 1'b0;
      rc(A_ISTAT, 16'h0080, "istat100");
      w(4);
      chk("int100", 16'(o_mgmt_interrupt_n), 16'h0001);
      wr(A_EXT2, 16'hc000);
      @(posedge i_clk) i_early_fail <= 1'b1;
      w(4);
      chk("early", 16'(o_link_loss_alert_pin), 16'h0001);
      @(posedge i_clk) i_early_fail <= 1'b0;
      w(4);
      chk("early", 16'(o_link_loss_alert_pin), 16'h0000);
      wr(A_IMASK, 16'h0040);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge i_clk) i_speed100 <= s[0];
         @(posedge i_clk) i_magic_det <= 1'b1;
         @(posedge i_clk) i_magic_det <= 1'b0;
         w(3);
         chk("wake_int", 16'(o_mgmt_interrupt_n), 16'h0000);
         rc(A_ISTAT, 16'h0040, "wake_stat");
      end
      wr(A_LEDBEH, 16'h000c);
      @(posedge i_clk) i_collision <= 1'b1;
      // the first two edges may be partial phases, only the third is a full half period
      repeat (3) led_edge(0, k);
      chk("blink_half", 16'(k), 16'(25 * MSC));
      wr(A_LEDEXT, 16'h0800);
      @(posedge i_clk) hold_pin <= 1'b1;
      w(4);
      @(posedge i_clk) hold_pin <= 1'b0;
      repeat (3) led_edge(1, k);
      chk("boot_blink", 16'(k), 16'(25 * MSC));
      end_of_test();
   end
endmodule
`default_nettype wire
